// [include/xor_array_defs.svh]
// Function
// - Twenty inputs, true and inverted, feed one AND plane; fixed ORs give ten outputs.
// - Each output is combinatorial or passes an XOR into a D flip-flop.
// - The XOR joins two sums so a state bit can hold or toggle.
// - Registered outputs feed their state back into the AND plane.
// - Outputs are three-state and pins can act as bidirectional lines.
// - All output flip-flops clear on a rising clock edge while reset_i is high.
// - Testers may preload the output flip-flops directly without sequencing.
// - A blown security fuse refuses further verification readback of the pattern.
// - A product term is true only when every still-connected line is high.
// - A term connected to both phases of one input stays low, as unprogrammed.
`ifndef XOR_ARRAY_DEFS_SVH
`define XOR_ARRAY_DEFS_SVH

`define ARRAY_INPUTS 20
`define LINE_COUNT 40
`define OUTPUT_COUNT 10
`define DEDICATED_INPUTS 10
`define TERMS_PER_OUTPUT 5
`define TERM_ROWS 50
`define ROW_ADDR_BITS 6
`define MODE_ROW 6'h32
`define OE_TERM 0
`define SUM_A_FIRST 1
`define SUM_B_FIRST 3
`define PIN_SYNC_WIDTH 21
`define REG_RESET_VALUE 10'h000
`define MODE_BLANK_VALUE 10'h000
`define ROW_INTACT_VALUE 40'hFFFFFFFFFF
`define SECURE_RESET_VALUE 1'b0

`endif

// [include/xor_array_pkg.sv]
`include "xor_array_defs.svh"

package xor_array_pkg;

    typedef enum logic {
        OUT_COMB,
        OUT_REG
    } out_mode_type;

    typedef struct packed {
        logic write;
        logic [`ROW_ADDR_BITS-1:0] row;
        logic [`LINE_COUNT-1:0] data;
    } fuse_write_type;

    typedef struct packed {
        logic read;
        logic [`ROW_ADDR_BITS-1:0] row;
    } fuse_read_type;

    typedef struct packed {
        logic valid;
        logic refused;
        logic [`LINE_COUNT-1:0] data;
    } fuse_answer_type;

endpackage

// [hw/product_term.sv]
`timescale 1ns/1ps
`default_nettype none

module product_term #(
    parameter int LINES = 40
) (
    // Array lines and the fuse row for this term
    input wire logic [LINES-1:0] lines_i,
    input wire logic [LINES-1:0] intact_i,
    // Term result
    output logic term_o
);

    // A blown fuse (0) forces its line to read as high, so only connected lines count.
    // Both phases of one input connected can never both be high, so the term stays low.
    assign term_o = &(lines_i | ~intact_i);

endmodule

`default_nettype wire

// [hw/xor_registered_logic_array.sv]
`timescale 1ns/1ps
`default_nettype none
`include "xor_array_defs.svh"

module xor_registered_logic_array (
    // Clock and power-up reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Dedicated input pins and the register output-enable pin
    input wire logic [`DEDICATED_INPUTS-1:0] in_pin_i,
    input wire logic reg_oe_n_i,
    // Output pins, three signals each
    input wire logic [`OUTPUT_COUNT-1:0] io_in_i,
    output logic [`OUTPUT_COUNT-1:0] io_out_o,
    output logic [`OUTPUT_COUNT-1:0] io_oe_o,
    // Register preload for test
    input wire logic preload_i,
    input wire logic [`OUTPUT_COUNT-1:0] preload_data_i,
    // Fuse programming, verification and security
    input wire logic blank_i,
    input wire xor_array_pkg::fuse_write_type fuse_write_i,
    input wire xor_array_pkg::fuse_read_type fuse_read_i,
    input wire logic secure_blow_i,
    output xor_array_pkg::fuse_answer_type fuse_answer_o,
    output logic secure_o,
    output logic write_refused_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Fuse storage

    // Fuses are nonvolatile, so reset leaves them alone; only blank_i restores
    // the unprogrammed die, where every fuse is intact.
    logic [`LINE_COUNT-1:0] fuse_mem [`TERM_ROWS];
    logic [`OUTPUT_COUNT-1:0] mode_reg;
    logic secure_reg;

    wire write_ok = fuse_write_i.write & ~secure_reg;
    wire write_term = write_ok & (fuse_write_i.row < `ROW_ADDR_BITS'(`TERM_ROWS));
    wire write_mode = write_ok & (fuse_write_i.row == `MODE_ROW);

    always_ff @(posedge mclk_i) begin
        if (blank_i) begin
            for (int r = 0; r < `TERM_ROWS; r++) begin
                fuse_mem[r] <= `ROW_INTACT_VALUE;
            end
        end else if (write_term) begin
            fuse_mem[fuse_write_i.row] <= fuse_write_i.data;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (blank_i) begin
            mode_reg <= `MODE_BLANK_VALUE;
            secure_reg <= `SECURE_RESET_VALUE;
        end else begin
            if (write_mode) begin
                mode_reg <= fuse_write_i.data[`OUTPUT_COUNT-1:0];
            end
            if (secure_blow_i) begin
                secure_reg <= 1'b1;
            end
        end
    end

    assign secure_o = secure_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Verification readback

    xor_array_pkg::fuse_answer_type answer_reg;
    xor_array_pkg::fuse_answer_type answer_next;
    logic refused_reg;

    wire read_ok = fuse_read_i.read & ~secure_reg;
    wire read_mode = fuse_read_i.row == `MODE_ROW;
    wire read_term = fuse_read_i.row < `ROW_ADDR_BITS'(`TERM_ROWS);
    wire [`LINE_COUNT-1:0] read_mode_data = {{(`LINE_COUNT-`OUTPUT_COUNT){1'b0}}, mode_reg};
    wire [`LINE_COUNT-1:0] read_term_data = read_term ? fuse_mem[fuse_read_i.row] : '0;

    always_comb begin
        answer_next.valid = read_ok;
        answer_next.refused = fuse_read_i.read & secure_reg;
        // A refused read returns zeros so nothing of the pattern leaks.
        answer_next.data = '0;
        if (read_ok) begin
            answer_next.data = read_mode ? read_mode_data : read_term_data;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            answer_reg <= '0;
            refused_reg <= 1'b0;
        end else begin
            answer_reg <= answer_next;
            refused_reg <= fuse_write_i.write & secure_reg;
        end
    end

    assign fuse_answer_o = answer_reg;
    assign write_refused_o = refused_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin input conditioning

    // A pin level is accepted only once the second and third stages agree,
    // which costs four cycles of latency but rejects single-cycle glitches.
    logic [`PIN_SYNC_WIDTH-1:0] sync1_reg;
    logic [`PIN_SYNC_WIDTH-1:0] sync2_reg;
    logic [`PIN_SYNC_WIDTH-1:0] sync3_reg;
    logic [`PIN_SYNC_WIDTH-1:0] pin_reg;

    wire [`PIN_SYNC_WIDTH-1:0] pin_raw = {reg_oe_n_i, io_in_i, in_pin_i};
    wire [`PIN_SYNC_WIDTH-1:0] agree = ~(sync2_reg ^ sync3_reg);
    wire [`PIN_SYNC_WIDTH-1:0] pin_next = (agree & sync3_reg) | (~agree & pin_reg);

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            pin_reg <= '0;
        end else begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_reg <= pin_next;
        end
    end

    wire [`DEDICATED_INPUTS-1:0] in_level = pin_reg[`DEDICATED_INPUTS-1:0];
    wire [`OUTPUT_COUNT-1:0] io_level = pin_reg[`DEDICATED_INPUTS +: `OUTPUT_COUNT];
    wire reg_oe_n_level = pin_reg[`PIN_SYNC_WIDTH-1];

    ////////////////////////////////////////////////////////////////////////////
    // AND plane

    logic [`OUTPUT_COUNT-1:0] state_reg;

    // Registered outputs feed back their own state; combinatorial ones read
    // their pin, so an undriven pin can serve as an extra input.
    wire [`OUTPUT_COUNT-1:0] feedback = (mode_reg & state_reg) | (~mode_reg & io_level);
    wire [`ARRAY_INPUTS-1:0] array_in = {feedback, in_level};
    logic [`LINE_COUNT-1:0] lines;
    logic [`TERM_ROWS-1:0] terms;

    always_comb begin
        for (int k = 0; k < `ARRAY_INPUTS; k++) begin
            lines[2*k] = array_in[k];
            lines[2*k+1] = ~array_in[k];
        end
    end

    for (genvar t = 0; t < `TERM_ROWS; t++) begin : g_term
        product_term #(
            .LINES(`LINE_COUNT)
        ) u_term (
            .lines_i(lines),
            .intact_i(fuse_mem[t]),
            .term_o(terms[t])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // OR, XOR and output stage

    logic [`OUTPUT_COUNT-1:0] sum_a;
    logic [`OUTPUT_COUNT-1:0] sum_b;
    logic [`OUTPUT_COUNT-1:0] term_oe;

    always_comb begin
        for (int o = 0; o < `OUTPUT_COUNT; o++) begin
            term_oe[o] = terms[o*`TERMS_PER_OUTPUT + `OE_TERM];
            sum_a[o] = terms[o*`TERMS_PER_OUTPUT + `SUM_A_FIRST]
                | terms[o*`TERMS_PER_OUTPUT + `SUM_A_FIRST + 1];
            sum_b[o] = terms[o*`TERMS_PER_OUTPUT + `SUM_B_FIRST]
                | terms[o*`TERMS_PER_OUTPUT + `SUM_B_FIRST + 1];
        end
    end

    // One sum picks the bit, the other decides whether to invert it: with a
    // feedback term in one sum the state holds or toggles.
    wire [`OUTPUT_COUNT-1:0] xor_result = sum_a ^ sum_b;
    wire [`OUTPUT_COUNT-1:0] comb_result = sum_a | sum_b;
    wire [`OUTPUT_COUNT-1:0] state_next = preload_i ? preload_data_i : xor_result;

    logic [`OUTPUT_COUNT-1:0] out_reg;
    logic [`OUTPUT_COUNT-1:0] oe_reg;
    wire [`OUTPUT_COUNT-1:0] out_next = (mode_reg & state_next) | (~mode_reg & comb_result);
    wire [`OUTPUT_COUNT-1:0] oe_next = (mode_reg & {`OUTPUT_COUNT{~reg_oe_n_level}})
        | (~mode_reg & term_oe);

    // Every flip-flop loads on the same rising edge; combinatorial outputs
    // also pass a flop here so the pins never carry array glitches.
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_reg <= `REG_RESET_VALUE;
            out_reg <= `REG_RESET_VALUE;
            oe_reg <= '0;
        end else begin
            state_reg <= state_next;
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    assign io_out_o = out_reg;
    assign io_oe_o = oe_reg;

endmodule

`default_nettype wire

// [test/xor_array_props.sv]
`timescale 1ns/1ps
`default_nettype none
module xor_array_props (
    // Watched pins
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic blank_i,
    input wire logic secure_blow_i,
    input wire logic [9:0] io_out_o,
    input wire logic [9:0] io_oe_o,
    input wire xor_array_pkg::fuse_write_type fuse_write_i,
    input wire xor_array_pkg::fuse_read_type fuse_read_i,
    input wire xor_array_pkg::fuse_answer_type fuse_answer_o,
    input wire logic secure_o,
    input wire logic write_refused_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    reset_clear_a: assert property ($fell(reset_i) |-> io_out_o == 10'h000 && io_oe_o == 10'h000)
        else $error("outputs not cleared by reset");
    read_valid_a: assert property (fuse_read_i.read && !secure_o && !blank_i |=> fuse_answer_o.valid)
        else $error("open read not answered");
    read_refuse_a: assert property (fuse_read_i.read && secure_o && !blank_i |=>
        fuse_answer_o.refused && !fuse_answer_o.valid && fuse_answer_o.data == 40'h0)
        else $error("secured read not refused");
    write_refuse_a: assert property (fuse_write_i.write && secure_o && !blank_i |=> write_refused_o)
        else $error("secured write not refused");
    refuse_cause_a: assert property (write_refused_o |-> $past(fuse_write_i.write && secure_o))
        else $error("refusal without cause");
    answer_cause_a: assert property (fuse_answer_o.valid |-> $past(fuse_read_i.read))
        else $error("answer without read");
    secure_hold_a: assert property (secure_o && !blank_i |=> secure_o)
        else $error("security fuse lost");
    secure_set_a: assert property (secure_blow_i && !blank_i |=> secure_o)
        else $error("security fuse not set");
endmodule
`default_nettype wire

// [test/board_logic.sv]
`timescale 1ns/1ps
`default_nettype none
module board_logic (
    // Clock and board drive
    input wire logic mclk_i,
    input wire logic [9:0] drive_i,
    input wire logic [9:0] drive_en_i,
    // Device pin signals
    input wire logic [9:0] io_out_i,
    input wire logic [9:0] io_oe_i,
    output logic [9:0] io_in_o
);
    // A pin nobody drives floats, so it shows a level that changes every cycle.
    logic [9:0] float_reg = 10'h155;
    always @(posedge mclk_i) begin
        float_reg <= ~float_reg;
    end
    assign io_in_o = (io_oe_i & io_out_i) | (~io_oe_i & ((drive_en_i & drive_i) | (~drive_en_i & float_reg)));
endmodule
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [9:0] in_pin_i = 10'h000;
    logic reg_oe_n_i = 1'b0;
    logic [9:0] io_in_i, io_out_o, io_oe_o;
    logic preload_i = 1'b0;
    logic [9:0] preload_data_i = 10'h000;
    logic blank_i = 1'b0;
    xor_array_pkg::fuse_write_type fuse_write_i = '0;
    xor_array_pkg::fuse_read_type fuse_read_i = '0;
    logic secure_blow_i = 1'b0;
    xor_array_pkg::fuse_answer_type fuse_answer_o, notes[$];
    logic secure_o, write_refused_o, v;
    logic [39:0] d;
    int n_errors = 0;
    int compares = 0;
    always #12.5 mclk_i = ~mclk_i;
    xor_registered_logic_array i_dut (.mclk_i, .reset_i, .in_pin_i, .reg_oe_n_i, .io_in_i, .io_out_o, .io_oe_o,
        .preload_i, .preload_data_i, .blank_i, .fuse_write_i, .fuse_read_i, .secure_blow_i, .fuse_answer_o,
        .secure_o, .write_refused_o);
    board_logic i_board (.mclk_i, .drive_i(~in_pin_i), .drive_en_i(10'h3FC), .io_out_i(io_out_o),
        .io_oe_i(io_oe_o), .io_in_o(io_in_i));
    task automatic fail(input string m);
        $display("MISMATCH %0t %s", $time, m);
        n_errors++;
    endtask
    task automatic check_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) fail("pin level");
    endtask
    task automatic check_answer(input xor_array_pkg::fuse_answer_type got, exp);
        compares++;
        if (got !== exp) fail("fuse answer");
    endtask
    task automatic wr(input logic [5:0] r, input logic [39:0] dat);
        @(posedge mclk_i);
        fuse_write_i <= '{1'b1, r, dat};
        @(posedge mclk_i);
        fuse_write_i.write <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] r, input xor_array_pkg::fuse_answer_type exp);
        @(posedge mclk_i);
        fuse_read_i <= '{1'b1, r};
        notes.push_back(exp);
        @(posedge mclk_i);
        fuse_read_i.read <= 1'b0;
    endtask
    task automatic conclude;
        if (notes.size() != 0) fail("expected answer never came");
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////
    always @(posedge mclk_i) begin
        #1;
        if (fuse_answer_o.valid === 1'b1 || fuse_answer_o.refused === 1'b1) begin
            if (notes.size() == 0) fail("unexpected answer");
            else check_answer(fuse_answer_o, notes.pop_front());
        end
    end
    initial begin
        repeat (5000) @(posedge mclk_i);
        fail("timeout");
        conclude();
    end
    initial begin
        void'($urandom(20));
        repeat (3) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        blank_i <= 1'b1;
        @(posedge mclk_i);
        blank_i <= 1'b0;
        for (int r = 10; r < 13; r++) begin
            d = 40'({$urandom, $urandom});
            wr(6'(r), d);
            rd(6'(r), {2'b10, d});
        end
        rd(6'h3F, {2'b10, 40'h0});
        // Output 0: enable term with every fuse blown, sums of input 0 and not input 1.
        wr(6'h00, 40'h0);
        wr(6'h01, 40'h1);
        wr(6'h03, 40'h8);
        // Output 1 registered: sum A stuck high, sum B follows its own state, so it toggles.
        wr(6'h06, 40'h0);
        wr(6'h08, 40'h400000);
        wr(6'h32, 40'hF000000002);
        rd(6'h32, {2'b10, 40'h2});
        repeat (4) begin
            @(posedge mclk_i);
            in_pin_i <= 10'($urandom);
            repeat (6) @(posedge mclk_i);
            #1;
            check_bit(io_out_o[0], in_pin_i[0] | ~in_pin_i[1]);
            check_bit(io_oe_o[0], 1'b1);
        end
        @(posedge mclk_i);
        preload_i <= 1'b1;
        preload_data_i <= 10'($urandom);
        @(posedge mclk_i);
        preload_i <= 1'b0;
        #1;
        v = preload_data_i[1];
        check_bit(io_out_o[1], v);
        repeat (4) begin
            @(posedge mclk_i);
            #1;
            v = ~v;
            check_bit(io_out_o[1], v);
        end
        check_bit(io_oe_o[1], 1'b1);
        @(posedge mclk_i);
        reg_oe_n_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        #1;
        check_bit(io_oe_o[1], 1'b0);
        @(posedge mclk_i);
        reset_i <= 1'b1;
        @(posedge mclk_i);
        reset_i <= 1'b0;
        #1;
        check_bit(io_out_o[1], 1'b0);
        @(posedge mclk_i);
        #1;
        check_bit(io_out_o[1], 1'b1);
        @(posedge mclk_i);
        secure_blow_i <= 1'b1;
        @(posedge mclk_i);
        secure_blow_i <= 1'b0;
        rd(6'h01, {2'b01, 40'h0});
        wr(6'h01, 40'h0);
        #1;
        check_bit(write_refused_o, 1'b1);
        repeat (2) @(posedge mclk_i);
        conclude();
    end
endmodule
bind xor_registered_logic_array xor_array_props i_props (.mclk_i, .reset_i, .blank_i, .secure_blow_i, .io_out_o,
    .io_oe_o, .fuse_write_i, .fuse_read_i, .fuse_answer_o, .secure_o, .write_refused_o);
`default_nettype wire
